// File: isra_pkg.sv
// Shared constants and types of the two-wire register access link
`default_nettype none
package isra_pkg;
	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [6:0] DEV_ADDR = 7'h11;
	localparam logic [7:0] REG_REVISION = 8'h01;
	localparam logic [7:0] REG_ENABLE = 8'h0a;
	localparam logic [7:0] REG_FLAGS1 = 8'h0b;
	localparam logic [7:0] REG_FLAGS2 = 8'h10;
	localparam logic [7:0] REG_LAST = 8'h10;
	localparam int REG_COUNT = 17;
	// Revision code; arbitrary value
	localparam logic [7:0] REVISION_ID = 8'h5a;
	localparam int FLAGS1_THERMAL_BIT = 0;
	localparam int EN_BACKLIGHT_BIT = 0;
	localparam int EN_BIAS_BIT = 1;
	localparam int EN_FLASH_BIT = 2;
	localparam logic [7:0] REG_RESET [REG_COUNT] = '{
		8'h00, 8'h00, 8'h30, 8'h0d, 8'h07, 8'hff, 8'h3e, 8'h2f, 8'h03,
		8'h00, 8'h00, 8'h00, 8'h18, 8'h1e, 8'h1e, 8'h1c, 8'h00};

	// ***************************************************************
	// Bus timing
	// ***************************************************************
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int CLK_MHZ = 125;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC = (SCL_PERIOD_NS * CLK_MHZ + 3999) / 4000;
	localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [1:0] {
		MODE_SHUTDOWN,
		MODE_STANDBY,
		MODE_NORMAL
	} isra_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} isra_dst_e;
	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BYTE,
		H_STOP
	} isra_hst_e;
endpackage
`default_nettype wire

// File: isra_link_if.sv
// Open-drain two-wire link joining the bus master and the device
`timescale 1ns/10ps
`default_nettype none
interface isra_link_if;
	logic scl_m_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// Wired-and with pull-ups: a line is low while any party pulls it
	assign scl = ~scl_m_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);

	modport dev (input scl, input sda, output sda_s_oe);
	modport host (input sda, output scl_m_oe, output sda_m_oe);
endinterface
`default_nettype wire

// File: isra_dev.sv
// Device end: serial slave, register file, operating modes, thermal fault
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Over-temperature disables all power outputs
// - Over-temperature sets thermal flag bit 0
// - Flag clears on flags read or enable toggle
// - Enable low holds shutdown
// - Standby accepts writes, outputs stay off
// - Three blocks enabled independently in normal
// - Sample data while clock high
// - Data change with clock high aborts transaction
// - Eight bits, MSB first, then acknowledge
// - Master makes start and stop conditions
// - Bus busy from start until stop
// - Repeated start restarts address decoding
// - Receiver pulls data low on ninth clock
// - Master ends read with negative acknowledge
// - Fixed address 0x11, eighth bit direction
// - Acknowledge only own address
// - Write sends pointer then data bytes
// - Pointer increments after each written byte
// - Read: write pointer, restart, read
// - Master acknowledge advances read pointer
// - Enable low resets registers and interface
module isra_dev (
	input wire logic link_clk,
	input wire logic srst,
	input wire logic chip_en,
	input wire logic over_temperature_fault,
	isra_link_if.dev link,
	output logic backlight_on,
	output logic display_power_rails_on,
	output logic flash_on,
	output isra_pkg::isra_mode_e dev_mode,
	output logic thermal_flag,
	output logic bus_busy
);
	// ***************************************************************
	// Synchronisers
	// ***************************************************************
	logic [1:0] scl_sync_reg, sda_sync_reg, en_sync_reg, ot_sync_reg;
	logic scl_s, sda_s, en_s, ot_s, rst_all;
	always_ff @(posedge link_clk) begin
		if (srst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			en_sync_reg <= 2'h0;
			ot_sync_reg <= 2'h0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], link.scl};
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			en_sync_reg <= {en_sync_reg[0], chip_en};
			ot_sync_reg <= {ot_sync_reg[0], over_temperature_fault};
		end
	end
	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign en_s = en_sync_reg[1];
	assign ot_s = ot_sync_reg[1];
	// Enable low acts as a global reset of everything below
	assign rst_all = srst | ~en_s;

	// ***************************************************************
	// Bus condition detection
	// ***************************************************************
	logic scl_prev_reg, sda_prev_reg, busy_reg;
	logic scl_rise, scl_fall, start_det, stop_det;
	always_ff @(posedge link_clk) begin
		if (rst_all) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end
	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;
	assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	always_ff @(posedge link_clk) begin
		if (rst_all) begin
			busy_reg <= 1'b0;
		end else if (start_det) begin
			busy_reg <= 1'b1;
		end else if (stop_det) begin
			busy_reg <= 1'b0;
		end
	end

	// ***************************************************************
	// Register file and thermal flag
	// ***************************************************************
	logic [7:0] regs_reg [isra_pkg::REG_COUNT];
	isra_pkg::isra_dst_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_idx_reg;
	logic fault_reg, rw_reg, sda_oe_reg, mack_reg;
	logic [7:0] shift_reg, ptr_reg, rd_cur, rd_nxt;
	logic byte_end, wr_en, flag_clr;
	function automatic logic writable(input logic [7:0] a);
		writable = (a != 8'h00) && (a <= isra_pkg::REG_LAST) &&
			(a != isra_pkg::REG_REVISION) &&
			(a != isra_pkg::REG_FLAGS1) && (a != isra_pkg::REG_FLAGS2);
	endfunction
	function automatic logic [7:0] read_reg(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == isra_pkg::REG_FLAGS1) begin
			v[isra_pkg::FLAGS1_THERMAL_BIT] = fault_reg;
		end else if (a == isra_pkg::REG_REVISION) begin
			v = isra_pkg::REVISION_ID;
		end else if (writable(a)) begin
			v = regs_reg[a[4:0]];
		end
		return v;
	endfunction
	// A process also follows register and flag changes behind the pointer
	always_comb begin
		rd_cur = read_reg(ptr_reg);
		rd_nxt = read_reg(ptr_reg + 8'h01);
	end
	assign byte_end = scl_fall && (state_reg == isra_pkg::ST_RX) &&
		(bit_cnt_reg == isra_pkg::BITS_PER_BYTE);
	// Data bytes land whatever the mode, so standby takes writes
	assign wr_en = byte_end && (byte_idx_reg == 2'h2) &&
		writable(ptr_reg);
	// A read of the flags completes at the master's acknowledge slot
	assign flag_clr = scl_fall && (state_reg == isra_pkg::ST_TX_ACK) &&
		(ptr_reg == isra_pkg::REG_FLAGS1) && !start_det && !stop_det;
	always_ff @(posedge link_clk) begin
		if (rst_all) begin
			for (int i = 0; i < isra_pkg::REG_COUNT; i++) begin
				regs_reg[i] <= isra_pkg::REG_RESET[i];
			end
		end else if (wr_en) begin
			regs_reg[ptr_reg[4:0]] <= shift_reg;
		end
	end
	always_ff @(posedge link_clk) begin
		if (rst_all) begin
			fault_reg <= 1'b0;
		end else if (ot_s) begin
			fault_reg <= 1'b1;
		end else if (flag_clr) begin
			fault_reg <= 1'b0;
		end
	end

	// ***************************************************************
	// Serial slave engine
	// ***************************************************************
	always_ff @(posedge link_clk) begin
		if (rst_all) begin
			state_reg <= isra_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			byte_idx_reg <= 2'h0;
			rw_reg <= 1'b0;
			ptr_reg <= 8'h00;
			sda_oe_reg <= 1'b0;
			mack_reg <= 1'b0;
		end else if (start_det) begin
			// Start or repeated start: decode an address again
			state_reg <= isra_pkg::ST_RX;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			sda_oe_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= isra_pkg::ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise) begin
			if (state_reg == isra_pkg::ST_RX) begin
				shift_reg <= {shift_reg[6:0], sda_s};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (state_reg == isra_pkg::ST_TX) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (state_reg == isra_pkg::ST_TX_ACK) begin
				mack_reg <= ~sda_s;
			end
		end else if (scl_fall) begin
			unique case (state_reg)
			isra_pkg::ST_IDLE: sda_oe_reg <= 1'b0;
			isra_pkg::ST_RX: begin
				if (bit_cnt_reg == isra_pkg::BITS_PER_BYTE) begin
					if (byte_idx_reg == 2'h0 &&
						shift_reg[7:1] != isra_pkg::DEV_ADDR) begin
						state_reg <= isra_pkg::ST_IDLE;
					end else begin
						state_reg <= isra_pkg::ST_RX_ACK;
						sda_oe_reg <= 1'b1;
						if (byte_idx_reg == 2'h0) begin
							rw_reg <= shift_reg[0];
						end else if (byte_idx_reg == 2'h1) begin
							ptr_reg <= shift_reg;
						end
					end
				end
			end
			isra_pkg::ST_RX_ACK: begin
				bit_cnt_reg <= 4'h0;
				if (byte_idx_reg == 2'h2) begin
					ptr_reg <= ptr_reg + 8'h01;
				end else begin
					byte_idx_reg <= byte_idx_reg + 2'h1;
				end
				if (byte_idx_reg == 2'h0 && rw_reg) begin
					state_reg <= isra_pkg::ST_TX;
					shift_reg <= rd_cur;
					sda_oe_reg <= ~rd_cur[7];
				end else begin
					state_reg <= isra_pkg::ST_RX;
					sda_oe_reg <= 1'b0;
				end
			end
			isra_pkg::ST_TX: begin
				if (bit_cnt_reg == isra_pkg::BITS_PER_BYTE) begin
					state_reg <= isra_pkg::ST_TX_ACK;
					sda_oe_reg <= 1'b0;
				end else begin
					shift_reg <= {shift_reg[6:0], 1'b0};
					sda_oe_reg <= ~shift_reg[6];
				end
			end
			isra_pkg::ST_TX_ACK: begin
				if (mack_reg) begin
					state_reg <= isra_pkg::ST_TX;
					ptr_reg <= ptr_reg + 8'h01;
					shift_reg <= rd_nxt;
					sda_oe_reg <= ~rd_nxt[7];
					bit_cnt_reg <= 4'h0;
				end else begin
					state_reg <= isra_pkg::ST_IDLE;
				end
			end
			endcase
		end
	end
	assign link.sda_s_oe = sda_oe_reg;

	// ***************************************************************
	// Operating modes and power outputs
	// ***************************************************************
	logic [7:0] en_reg;
	assign en_reg = regs_reg[isra_pkg::REG_ENABLE[4:0]];
	always_ff @(posedge link_clk) begin
		if (rst_all) begin
			dev_mode <= isra_pkg::MODE_SHUTDOWN;
			backlight_on <= 1'b0;
			display_power_rails_on <= 1'b0;
			flash_on <= 1'b0;
			thermal_flag <= 1'b0;
			bus_busy <= 1'b0;
		end else begin
			dev_mode <= (en_reg[2:0] == 3'h0) ? isra_pkg::MODE_STANDBY :
				isra_pkg::MODE_NORMAL;
			backlight_on <= en_reg[isra_pkg::EN_BACKLIGHT_BIT] & ~ot_s;
			display_power_rails_on <= en_reg[isra_pkg::EN_BIAS_BIT] & ~ot_s;
			flash_on <= en_reg[isra_pkg::EN_FLASH_BIT] & ~ot_s;
			thermal_flag <= fault_reg;
			bus_busy <= busy_reg;
		end
	end
endmodule
`default_nettype wire

// File: isra_host.sv
// Bus master end: single register write or read over the two-wire link
`timescale 1ns/10ps
`default_nettype none
module isra_host (
	input wire logic clock,
	input wire logic srst,
	isra_link_if.host link,
	input wire logic req,
	input wire logic is_read,
	input wire logic [7:0] reg_ptr,
	input wire logic [7:0] wdata,
	output logic ready,
	output logic done,
	output logic [7:0] rdata,
	output logic nack_err
);
	// ***************************************************************
	// Line sampling and quarter-period timing
	// ***************************************************************
	logic [1:0] sda_sync_reg;
	logic sda_s;
	isra_pkg::isra_hst_e state_reg;
	logic [6:0] qtr_reg;
	logic tick;

	always_ff @(posedge clock) begin
		if (srst) begin
			sda_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
		end
	end
	assign sda_s = sda_sync_reg[1];

	// The bus clock is this divider: four quarters per bit
	always_ff @(posedge clock) begin
		if (srst || state_reg == isra_pkg::H_IDLE || qtr_reg == 7'h00) begin
			qtr_reg <= isra_pkg::QTR_LAST;
		end else begin
			qtr_reg <= qtr_reg - 7'h01;
		end
	end
	assign tick = (qtr_reg == 7'h00) && (state_reg != isra_pkg::H_IDLE);

	// ***************************************************************
	// Transfer sequencer
	// ***************************************************************
	logic [1:0] phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_no_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic rd_reg;
	logic err_reg;
	logic [7:0] ptr_reg;
	logic [7:0] data_reg;
	logic last_byte;
	logic master_rx;

	function automatic logic [7:0] byte_val(input logic [1:0] n,
		input logic rd, input logic [7:0] p, input logic [7:0] d);
		logic [7:0] v;
		v = 8'hff;
		if (n == 2'h0) begin
			v = {isra_pkg::DEV_ADDR, 1'b0};
		end else if (n == 2'h1) begin
			v = p;
		end else if (n == 2'h2) begin
			v = rd ? {isra_pkg::DEV_ADDR, 1'b1} : d;
		end
		return v;
	endfunction

	assign last_byte = rd_reg ? (byte_no_reg == 2'h3) : (byte_no_reg == 2'h2);
	assign master_rx = rd_reg && (byte_no_reg == 2'h3);
	assign ready = (state_reg == isra_pkg::H_IDLE);

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= isra_pkg::H_IDLE;
			phase_reg <= 2'h0;
			bit_cnt_reg <= 4'h0;
			byte_no_reg <= 2'h0;
			tx_reg <= 8'hff;
			rx_reg <= 8'h00;
			rd_reg <= 1'b0;
			err_reg <= 1'b0;
			ptr_reg <= 8'h00;
			data_reg <= 8'h00;
			done <= 1'b0;
			rdata <= 8'h00;
			nack_err <= 1'b0;
		end else begin
			done <= 1'b0;
			if (state_reg == isra_pkg::H_IDLE) begin
				if (req) begin
					state_reg <= isra_pkg::H_START;
					phase_reg <= 2'h0;
					byte_no_reg <= 2'h0;
					rd_reg <= is_read;
					ptr_reg <= reg_ptr;
					data_reg <= wdata;
					err_reg <= 1'b0;
				end
			end else if (tick) begin
				phase_reg <= phase_reg + 2'h1;
				if (state_reg == isra_pkg::H_BYTE && phase_reg == 2'h2) begin
					if (bit_cnt_reg != isra_pkg::BITS_PER_BYTE) begin
						rx_reg <= {rx_reg[6:0], sda_s};
					end else if (!master_rx && sda_s) begin
						err_reg <= 1'b1;
					end
				end
				if (phase_reg == 2'h3) begin
					unique case (state_reg)
					isra_pkg::H_START: begin
						state_reg <= isra_pkg::H_BYTE;
						bit_cnt_reg <= 4'h0;
						tx_reg <= byte_val(byte_no_reg, rd_reg, ptr_reg,
							data_reg);
					end
					isra_pkg::H_BYTE: begin
						if (bit_cnt_reg != isra_pkg::BITS_PER_BYTE) begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							tx_reg <= {tx_reg[6:0], 1'b1};
						end else if (err_reg || last_byte) begin
							state_reg <= isra_pkg::H_STOP;
						end else if (rd_reg && byte_no_reg == 2'h1) begin
							state_reg <= isra_pkg::H_START;
							byte_no_reg <= 2'h2;
						end else begin
							byte_no_reg <= byte_no_reg + 2'h1;
							bit_cnt_reg <= 4'h0;
							tx_reg <= byte_val(byte_no_reg + 2'h1, rd_reg,
								ptr_reg, data_reg);
						end
					end
					isra_pkg::H_STOP: begin
						state_reg <= isra_pkg::H_IDLE;
						done <= 1'b1;
						nack_err <= err_reg;
						if (rd_reg && !err_reg) begin
							rdata <= rx_reg;
						end
					end
					isra_pkg::H_IDLE: begin
						state_reg <= isra_pkg::H_IDLE;
					end
					endcase
				end
			end
		end
	end

	// ***************************************************************
	// Line drive: quarter 0 and 3 clock low (stop: quarter 0 only), 1 and 2 clock high
	// ***************************************************************
	logic scl_low;
	logic sda_low;
	logic scl_oe_reg;
	logic sda_oe_reg;

	always_comb begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		unique case (state_reg)
		isra_pkg::H_IDLE: begin
			scl_low = 1'b0;
		end
		isra_pkg::H_START: begin
			scl_low = (phase_reg == 2'h0) || (phase_reg == 2'h3);
			sda_low = phase_reg[1];
		end
		isra_pkg::H_BYTE: begin
			scl_low = (phase_reg == 2'h0) || (phase_reg == 2'h3);
			// Ack slot always released: slave acks, or a master NACK
			sda_low = (bit_cnt_reg != isra_pkg::BITS_PER_BYTE) &&
				!master_rx && !tx_reg[7];
		end
		isra_pkg::H_STOP: begin
			scl_low = (phase_reg == 2'h0);
			sda_low = !phase_reg[1];
		end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			scl_oe_reg <= scl_low;
			sda_oe_reg <= sda_low;
		end
	end

	assign link.scl_m_oe = scl_oe_reg;
	assign link.sda_m_oe = sda_oe_reg;
endmodule
`default_nettype wire

// File: isra_props.sv
// Concurrent checks on the two-wire link and the device state
`timescale 1ns/10ps
`default_nettype none
module isra_props (
	input wire logic link_clk,
	input wire logic clock,
	input wire logic srst,
	input wire logic scl_m_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic chip_en,
	input wire logic over_temperature_fault,
	input wire logic backlight_on,
	input wire logic display_power_rails_on,
	input wire logic flash_on,
	input var isra_pkg::isra_mode_e dev_mode,
	input wire logic thermal_flag,
	input wire logic bus_busy,
	input wire logic ready,
	input wire logic done,
	input wire logic nack_err
);
	// ***************************************************************
	// Device side
	// ***************************************************************
	logic power_any;
	assign power_any = backlight_on | display_power_rails_on | flash_on;

	a_fault_powers_off: assert property (@(posedge link_clk)
		disable iff (srst) over_temperature_fault[*5] |-> !power_any)
		else $error("power output on during over-temperature");
	a_fault_sets_flag: assert property (@(posedge link_clk)
		disable iff (srst)
		(over_temperature_fault && chip_en)[*6] |-> thermal_flag)
		else $error("thermal flag not set by fault");
	a_shutdown_quiet: assert property (@(posedge link_clk)
		disable iff (srst) (!chip_en)[*5] |->
		dev_mode == isra_pkg::MODE_SHUTDOWN && !thermal_flag
		&& !bus_busy && !sda_s_oe && !power_any)
		else $error("device active while enable low");
	a_standby_dark: assert property (@(posedge link_clk)
		disable iff (srst) dev_mode == isra_pkg::MODE_STANDBY
		&& $past(dev_mode) == isra_pkg::MODE_STANDBY |-> !power_any)
		else $error("power output on in standby");
	a_start_sets_busy: assert property (@(posedge link_clk)
		disable iff (srst) scl && $past(scl) && $fell(sda)
		&& dev_mode != isra_pkg::MODE_SHUTDOWN |-> ##[1:6] bus_busy)
		else $error("start not seen as busy");
	a_stop_clears_busy: assert property (@(posedge link_clk)
		disable iff (srst) scl && $past(scl) && $rose(sda)
		|-> ##[1:6] !bus_busy)
		else $error("busy not cleared by stop");
	a_data_moves_low: assert property (@(posedge link_clk)
		disable iff (srst) $changed(sda_s_oe) |-> !scl)
		else $error("device data changed with clock high");
	a_ack_holds_high: assert property (@(posedge link_clk)
		disable iff (srst) sda_s_oe && $rose(scl) |-> sda_s_oe[*4])
		else $error("device released data during clock high");
	a_idle_releases: assert property (@(posedge link_clk)
		disable iff (srst) !bus_busy |-> !sda_s_oe)
		else $error("device pulls data while bus idle");

	// ***************************************************************
	// Master side
	// ***************************************************************
	a_host_idle_free: assert property (@(posedge clock)
		disable iff (srst) ready && $past(ready) |-> !scl_m_oe && !sda_m_oe)
		else $error("master holds a line while idle");

	cover property (@(posedge link_clk) disable iff (srst) $rose(bus_busy));
	cover property (@(posedge link_clk) disable iff (srst) $fell(thermal_flag));
	cover property (@(posedge link_clk) disable iff (srst)
		dev_mode == isra_pkg::MODE_NORMAL);
	cover property (@(posedge clock) disable iff (srst) done && nack_err);
endmodule
`default_nettype wire

// File: tb_i2c_slave_register_access.sv
// Self-checking bench joining the bus master end and the device end
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("unexpected at %0t: got %h expected %h", \
				$time, got, exp); \
		end \
	end
module tb_i2c_slave_register_access;
	logic clock = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	logic chip_en = 1'b0;
	logic over_temperature_fault = 1'b0;
	logic req = 1'b0;
	logic is_read = 1'b0;
	logic [7:0] reg_ptr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic ready, done, nack_err, thermal_flag, bus_busy;
	logic backlight_on, display_power_rails_on, flash_on;
	logic [7:0] rdata;
	isra_pkg::isra_mode_e dev_mode;
	integer seed = 32'h9e8e;
	int failures = 0;
	int samples_checked = 0;
	logic [7:0] val;
	logic [2:0] en;

	isra_link_if link_if ();
	isra_dev isra_dev_inst (.link_clk(link_clk), .srst(srst),
		.chip_en(chip_en), .over_temperature_fault(over_temperature_fault),
		.link(link_if), .backlight_on(backlight_on),
		.display_power_rails_on(display_power_rails_on), .flash_on(flash_on),
		.dev_mode(dev_mode), .thermal_flag(thermal_flag),
		.bus_busy(bus_busy));
	isra_host isra_host_inst (.clock(clock), .srst(srst), .link(link_if),
		.req(req), .is_read(is_read), .reg_ptr(reg_ptr), .wdata(wdata),
		.ready(ready), .done(done), .rdata(rdata), .nack_err(nack_err));
	isra_props checker_inst (.link_clk(link_clk), .clock(clock),
		.srst(srst), .scl_m_oe(link_if.scl_m_oe),
		.sda_m_oe(link_if.sda_m_oe), .sda_s_oe(link_if.sda_s_oe),
		.scl(link_if.scl), .sda(link_if.sda), .chip_en(chip_en),
		.over_temperature_fault(over_temperature_fault),
		.backlight_on(backlight_on),
		.display_power_rails_on(display_power_rails_on),
		.flash_on(flash_on), .dev_mode(dev_mode),
		.thermal_flag(thermal_flag), .bus_busy(bus_busy), .ready(ready),
		.done(done), .nack_err(nack_err));

	// ***************************************************************
	// Clocks and helpers
	// ***************************************************************
	initial begin
		forever #4 clock = ~clock;
	end
	initial begin
		#5 link_clk = 1'b1;
		forever #16 link_clk = ~link_clk;
	end

	function automatic isra_pkg::isra_mode_e exp_mode(input logic [2:0] e);
		return (e != 3'h0) ? isra_pkg::MODE_NORMAL : isra_pkg::MODE_STANDBY;
	endfunction

	function automatic logic [7:0] flags_byte(input logic flag);
		return {7'h00, flag};
	endfunction

	task automatic wait_link(input int k);
		repeat (k) @(posedge link_clk);
		@(negedge clock);
	endtask

	// One transfer through the master end, returns after its done pulse
	task automatic xfer(input logic rd, input logic [7:0] p,
		input logic [7:0] d);
		int n;
		@(negedge clock);
		req = 1'b1;
		is_read = rd;
		reg_ptr = p;
		wdata = d;
		@(negedge clock);
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge clock);
			n++;
			if (n == 1000 && chip_en) begin
				`CHK(bus_busy, 1'b1)
			end
		end
		if (n == 20000) begin
			failures++;
			$display("unexpected at %0t: done got %h expected %h",
				$time, 1'b0, 1'b1);
		end
		`CHK(bus_busy, 1'b0)
		`CHK(ready, 1'b1)
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ***************************************************************
	// Tests
	// ***************************************************************
	initial begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		chip_en = 1'b1;
		wait_link(8);
		`CHK(dev_mode, isra_pkg::MODE_STANDBY)
		xfer(1'b1, isra_pkg::REG_REVISION, 8'h00);
		`CHK(nack_err, 1'b0)
		`CHK(rdata, isra_pkg::REVISION_ID)
		$display("test standby_revision ended");

		val = 8'($random(seed));
		xfer(1'b0, 8'h03, val);
		`CHK({flash_on, display_power_rails_on, backlight_on}, 3'h0)
		xfer(1'b1, 8'h03, 8'h00);
		`CHK(nack_err, 1'b0)
		`CHK(rdata, val)
		$display("test write_readback ended");

		en = 3'($random(seed));
		if (en == 3'h0) begin
			en = 3'h5;
		end
		xfer(1'b0, isra_pkg::REG_ENABLE, {5'h00, en});
		wait_link(8);
		`CHK(dev_mode, exp_mode(en))
		`CHK({flash_on, display_power_rails_on, backlight_on}, en)
		$display("test enable_blocks ended");

		over_temperature_fault = 1'b1;
		wait_link(8);
		`CHK({flash_on, display_power_rails_on, backlight_on}, 3'h0)
		`CHK(thermal_flag, 1'b1)
		over_temperature_fault = 1'b0;
		wait_link(8);
		`CHK({flash_on, display_power_rails_on, backlight_on}, en)
		xfer(1'b1, isra_pkg::REG_FLAGS1, 8'h00);
		`CHK(rdata, flags_byte(1'b1))
		wait_link(8);
		`CHK(thermal_flag, 1'b0)
		$display("test thermal_fault ended");

		over_temperature_fault = 1'b1;
		wait_link(8);
		over_temperature_fault = 1'b0;
		chip_en = 1'b0;
		wait_link(8);
		`CHK(dev_mode, isra_pkg::MODE_SHUTDOWN)
		`CHK(thermal_flag, 1'b0)
		`CHK({flash_on, display_power_rails_on, backlight_on}, 3'h0)
		xfer(1'b0, 8'h03, ~val);
		`CHK(nack_err, 1'b1)
		chip_en = 1'b1;
		wait_link(8);
		xfer(1'b1, 8'h03, 8'h00);
		`CHK(rdata, isra_pkg::REG_RESET[3])
		`CHK(dev_mode, isra_pkg::MODE_STANDBY)
		$display("test enable_toggle ended");
		test_done();
	end

	initial begin
		repeat (100000) @(posedge clock);
		failures++;
		$display("unexpected at %0t: watchdog got %h expected %h",
			$time, 1'b1, 1'b0);
		test_done();
	end
endmodule
`undef CHK
`default_nettype wire
